// *** rtl/oai_defines.svh ***
// constants of the operand address and interrupt unit
`ifndef OAI_DEFINES_SVH
`define OAI_DEFINES_SVH
// core locations of the three index words
`define OAI_IDX1_ADDR 14'h0001
`define OAI_IDX2_ADDR 14'h0002
`define OAI_IDX3_ADDR 14'h0003
// start location after reset and first interrupt location (octal 20)
`define OAI_P_RST 14'h0000
`define OAI_VEC_BASE 14'h0010
// interrupt sources, index into the pending vector; lower index wins
`define OAI_INT_FAULT 0
`define OAI_INT_IOPAR 1
`define OAI_INT_PGPAR 2
`define OAI_INT_MANUAL 3
`define OAI_INT_NUM 4
// instruction word fields
`define OAI_IND_BIT 23
`define OAI_FN_HI 22
`define OAI_FN_LO 18
`define OAI_PAR_BIT 24
// operand type codes
`define OAI_K_FULL 2'h0
`define OAI_K_RH 2'h1
`define OAI_K_LH 2'h2
`define OAI_K_IMM 2'h3
// skip condition codes
`define OAI_L_PLUS 2'h0
`define OAI_L_MINUS 2'h1
`define OAI_L_ZERO 2'h2
`define OAI_L_NZERO 2'h3
// buffer register reset value
`define OAI_M_RST 25'h0000000
`endif

// *** rtl/oai_pkg.sv ***
// types shared by the operand address and interrupt unit
package oai_pkg;
  // instruction word: indirect, function, operand type, index select, address
  typedef struct packed {
    logic        ind;
    logic [4:0]  fn;
    logic [1:0]  k;
    logic [1:0]  b;
    logic [13:0] y;
  } oai_instr_t;
  // request to core memory; data is the buffer register with parity on top
  typedef struct packed {
    logic        start;
    logic        wr;
    logic [13:0] addr;
    logic [24:0] data;
  } oai_mem_req_t;
  // answer of the execution unit when the instruction finishes
  typedef struct packed {
    logic        done;
    logic        skipIf;
    logic        jumpIf;
    logic        jump;
    logic        setRet;
    logic        store;
    logic        halt;
    logic [23:0] data;
  } oai_exec_t;
  // operand handed to the execution unit
  typedef struct packed {
    logic        valid;
    logic [4:0]  fn;
    logic [1:0]  k;
    logic [13:0] ea;
    logic [23:0] opnd;
  } oai_opnd_t;
  // channel request and its answer
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        wide;
    logic        incr;
    logic [13:0] addr;
    logic [29:0] data;
  } oai_io_req_t;
  typedef struct packed {
    logic        ack;
    logic        parErr;
    logic [29:0] data;
  } oai_io_rsp_t;
  // sequencer states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_FETCH = 9'h002,
    ST_INDEX = 9'h004,
    ST_INDIR = 9'h008,
    ST_OPER  = 9'h010,
    ST_EXEC  = 9'h020,
    ST_RMW   = 9'h040,
    ST_WRITE = 9'h080,
    ST_IO    = 9'h100
  } oai_state_t;
endpackage

// *** rtl/oai_operand_fmt.sv ***
// operand formation: half and immediate options, store merge, skip test
`timescale 1ns/1ps
`default_nettype none
`include "oai_defines.svh"
module oai_operand_fmt (
  // location word, option and store data
  input  wire logic [1:0]  k,
  input  wire logic [23:0] word,
  input  wire logic [13:0] y,
  input  wire logic [23:0] stData,
  // formed values
  output logic      [23:0] fetchOp,
  output logic      [23:0] storeWord,
  output logic             cond
);
  // fetch and store forms; halves sign-extend from their own top bit
  // RL11 RL12 RL17 two's complement halves
  always_comb begin
    case (k)
      `OAI_K_RH: begin
        fetchOp   = {{13{word[11]}}, word[10:0]};
        storeWord = {word[23:12], stData[11:0]};
      end
      `OAI_K_LH: begin
        fetchOp   = {{13{word[23]}}, word[22:12]};
        storeWord = {stData[11], stData[10:0], word[11:0]};
      end
      `OAI_K_IMM: begin
        fetchOp   = {10'h000, y};
        storeWord = {word[23:14], stData[13:0]};
      end
      default: begin
        fetchOp   = word;
        storeWord = stData;
      end
    endcase
  end
  // skip test on the full word, the option field read as a skip code
  always_comb begin
    case (k)
      `OAI_L_PLUS:  cond = ~word[23];
      `OAI_L_MINUS: cond = word[23];
      `OAI_L_ZERO:  cond = (word == 24'h000000);
      default:      cond = (word != 24'h000000);
    endcase
  end
endmodule // oai_operand_fmt
`default_nettype wire

// *** rtl/oai_int_vector.sv ***
// fixed-priority interrupt selector and vector location
`timescale 1ns/1ps
`default_nettype none
`include "oai_defines.svh"
module oai_int_vector #(
  parameter int N = `OAI_INT_NUM
) (
  // pending sources
  input  wire logic [N-1:0] pend,
  // winner
  output logic      [N-1:0] grant,
  output logic              any,
  output logic      [13:0]  vecAddr
);
  // scan from the lowest priority up so the highest pending one remains
  always_comb begin
    grant   = '0;
    vecAddr = `OAI_VEC_BASE;
    for (int j = N - 1; j >= 0; j--) begin
      if (pend[j]) begin
        grant    = '0;
        grant[j] = 1'b1;
        vecAddr  = `OAI_VEC_BASE + 14'(j);
      end
    end
    any = |pend;
  end
endmodule // oai_int_vector
`default_nettype wire

// *** rtl/oai_unit.sv ***
// operand address and interrupt unit: sequencer, pointer, address and buffer registers
`timescale 1ns/1ps
`default_nettype none
`include "oai_defines.svh"
// Notes on behaviour
// RL1: pointer steps by one per instruction, by two when a skip is taken
// RL2: jump loads the pointer from the address field; return store saves pointer
// RL3: storage address latch takes its address when each memory access starts
// RL4: buffer clears at access start; read captures sensed word, writes it back
// RL5: write access ignores sensed word and writes the loaded buffer value
// RL6: buffer moves 24 data bits plus one parity bit checked on reads
// RL7: wide channel moves two 15-bit halves, low to Y, high to Y+1
// RL8: counter-increment register adds to control words and clock word
// RL9: decode indirect 23, function 22-18, option 17-16, index 15-14, address 13-0
// RL10: option applies after indexing and indirection; type 0 is full word
// RL11: right half fetch sign-extends bit 11; store keeps bits 12-23
// RL12: left half fetch takes 12-22, sign bit 23; store keeps bits 0-11
// RL13: immediate uses address field zero-extended; store replaces bits 0-13 only
// RL14: skip code: 0 plus or zero, 1 minus, 2 zero, 3 nonzero
// RL15: index word low 14 bits added to address; carry sets range overflow
// RL16: each index step costs one reference and precedes that level's indirection
// RL17: full and half words are two's complement, sign in leftmost bit
// RL18: interrupt fetches from fixed location and leaves the pointer unchanged
// RL19: interrupts taken only between instructions, highest priority first
// RL20: all-zero top six bits with trap setting vectors to location 20
// RL21: channel parity error vectors to 21, program parity error to 22
// RL22: manual interrupt while running vectors to location 23
module oai_unit #(
  parameter logic [31:0] LCODE_FN = 32'h00000000 // functions whose option field is a skip code
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // core memory, same clock
  output var  oai_pkg::oai_mem_req_t memReq,
  input  wire logic                 memSenseValid,
  input  wire logic [24:0]          memSense,
  input  wire logic                 memDone,
  // execution unit
  output var  oai_pkg::oai_opnd_t    opnd,
  input  wire oai_pkg::oai_exec_t    exe,
  // channel side
  input  wire oai_pkg::oai_io_req_t  ioReq,
  output var  oai_pkg::oai_io_rsp_t  ioRsp,
  // panel pins, asynchronous
  input  wire logic                 runSw,
  input  wire logic                 trapResp,
  input  wire logic                 chanParResp,
  input  wire logic                 progParResp,
  input  wire logic                 manualIntSw,
  // status
  input  wire logic                 clrOvf,
  output logic                      rangeOvf,
  output logic [13:0]               nextPtr,
  output logic                      intMode
);
  oai_pkg::oai_state_t  stReg, st_n;
  oai_pkg::oai_instr_t  iReg, i_n;
  oai_pkg::oai_io_req_t ioReg, io_n;
  oai_pkg::oai_io_rsp_t rspReg, rsp_n;
  oai_pkg::oai_opnd_t   opReg, op_n;
  logic [13:0] pReg, p_n, faReg, fa_n, sReg, s_n;
  logic [24:0] mReg, m_n;
  logic [23:0] sdReg, sd_n, zReg, z_n;
  logic [29:0] xReg, x_n;
  logic [3:0]  pendReg, pend_n, take, grant;
  logic        intReg, int_n, haltReg, halt_n, ovfReg, ovf_n;
  logic        waitReg, wait_n, stepReg, step_n, startReg, wrReg;
  logic [4:0]  syncAReg, syncBReg;
  logic        manPrevReg;
  logic        go, goWr, run, anyPend, cond, lcode, done, parBad, last, ioWr;
  logic [13:0] goAddr, seqP, vecAddr, ioAddr;
  logic [23:0] goData, fetchOp, storeWord, ioData;
  logic [14:0] idxSum;

  // two flops on every panel pin before any logic looks at it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncAReg   <= 5'h00;
      syncBReg   <= 5'h00;
      manPrevReg <= 1'b0;
    end else begin
      syncAReg   <= {manualIntSw, progParResp, chanParResp, trapResp, runSw};
      syncBReg   <= syncAReg;
      manPrevReg <= syncBReg[4];
    end
  end

  oai_operand_fmt u_fmt (
    .k         (iReg.k),
    .word      (mReg[23:0]),
    .y         (iReg.y),
    .stData    (sdReg),
    .fetchOp   (fetchOp),
    .storeWord (storeWord),
    .cond      (cond)
  );

  oai_int_vector #(.N(`OAI_INT_NUM)) u_vec (
    .pend    (pendReg),
    .grant   (grant),
    .any     (anyPend),
    .vecAddr (vecAddr)
  );

  // shared terms; the pointer takes no step after an instruction in interrupt mode, only a jump, return or taken skip moves it
  assign run    = syncBReg[0] & ~haltReg;
  assign done   = waitReg & memDone;
  // RL18 no increment
  assign seqP   = intReg ? pReg : pReg + 14'h0001;
  assign lcode  = LCODE_FN[iReg.fn];
  // RL15 carry into bit 14
  assign idxSum = {1'b0, iReg.y} + {1'b0, mReg[13:0]};
  // RL6 odd parity over 25 bits; a read with even parity is an error
  assign parBad = waitReg & ~wrReg & memSenseValid & ~(^memSense);
  // RL7 wide transfers use Y then Y+1; increments read then write the sum
  assign ioAddr = ioReg.addr + {13'h0000, stepReg & ioReg.wide};
  assign ioWr   = ioReg.incr ? stepReg : ioReg.wr;
  assign last   = ~(ioReg.wide | ioReg.incr) | stepReg;
  always_comb begin
    if (ioReg.incr) begin
      ioData = zReg;
    end else if (ioReg.wide) begin
      ioData = {9'h000, stepReg ? ioReg.data[29:15] : ioReg.data[14:0]};
    end else begin
      ioData = ioReg.data[23:0];
    end
  end

  // sequencer next state: at most one memory access per state visit; ST_IO takes two for wide or increment, ST_INDIR one per level
  always_comb begin
    st_n = stReg; i_n = iReg; p_n = pReg; fa_n = faReg; int_n = intReg;
    halt_n = haltReg & syncBReg[0];
    ovf_n = ovfReg & ~clrOvf;
    io_n = ioReg; step_n = stepReg; sd_n = sdReg; x_n = xReg; z_n = zReg;
    op_n = opReg;
    op_n.valid = 1'b0;
    rsp_n = rspReg;
    rsp_n.ack = 1'b0;
    take = 4'h0; go = 1'b0; goWr = 1'b0; goAddr = faReg; goData = 24'h000000;
    pend_n = 4'h0;
    case (stReg)
      oai_pkg::ST_IDLE: begin
        // refused in its own ack cycle, else taken twice
        if (ioReq.req && !rspReg.ack) begin
          io_n = ioReq;
          step_n = 1'b0;
          rsp_n.parErr = 1'b0;
          st_n = oai_pkg::ST_IO;
        end else if (run && !ioReq.req) begin
          // RL19 taken only here, between instructions, highest first
          int_n = anyPend;
          take = grant;
          fa_n = anyPend ? vecAddr : pReg;
          st_n = oai_pkg::ST_FETCH;
        end
      end
      oai_pkg::ST_FETCH: begin
        if (!waitReg) begin
          go = 1'b1;
          goAddr = faReg;
        end else if (memDone) begin
          // RL9 field split of the instruction word
          i_n = oai_pkg::oai_instr_t'(mReg[23:0]);
          if (mReg[`OAI_IND_BIT:`OAI_FN_LO] == 6'h00) begin
            // RL20 trap word completes at once
            pend_n[`OAI_INT_FAULT] = syncBReg[1];
            p_n = seqP;
            st_n = oai_pkg::ST_IDLE;
          end else if (mReg[15:14] != 2'h0) begin
            st_n = oai_pkg::ST_INDEX;
          end else if (mReg[`OAI_IND_BIT]) begin
            st_n = oai_pkg::ST_INDIR;
          end else begin
            st_n = oai_pkg::ST_OPER;
          end
        end
      end
      oai_pkg::ST_INDEX: begin
        // RL16 index step is its own reference, before indirection
        if (!waitReg) begin
          go = 1'b1;
          goAddr = {12'h000, iReg.b};
        end else if (memDone) begin
          // RL15 add index word, flag carry
          i_n.y = idxSum[13:0];
          i_n.b = 2'h0;
          if (idxSum[14]) begin
            ovf_n = 1'b1;
          end
          st_n = iReg.ind ? oai_pkg::ST_INDIR : oai_pkg::ST_OPER;
        end
      end
      oai_pkg::ST_INDIR: begin
        if (!waitReg) begin
          go = 1'b1;
          goAddr = iReg.y;
        end else if (memDone) begin
          // RL16 the indirect word brings its own index and indirect bits
          i_n.ind = mReg[`OAI_IND_BIT];
          i_n.b = mReg[15:14];
          i_n.y = mReg[13:0];
          if (mReg[15:14] != 2'h0) begin
            st_n = oai_pkg::ST_INDEX;
          end else if (!mReg[`OAI_IND_BIT]) begin
            st_n = oai_pkg::ST_OPER;
          end
        end
      end
      oai_pkg::ST_OPER: begin
        // RL10 option applied to the resolved address; RL13 immediate skips the fetch
        if ((iReg.k == `OAI_K_IMM && !lcode) || done) begin
          op_n = '{1'b1, iReg.fn, iReg.k, iReg.y, lcode ? mReg[23:0] : fetchOp};
          st_n = oai_pkg::ST_EXEC;
        end else if (!waitReg) begin
          go = 1'b1;
          goAddr = iReg.y;
        end
      end
      oai_pkg::ST_EXEC: begin
        if (exe.done) begin
          p_n = seqP;
          // RL2 jump loads the pointer in parallel; RL14 conditional forms
          if (exe.jump || (exe.jumpIf && cond)) begin
            p_n = iReg.y;
          end
          // RL1 skip adds one more
          if (exe.skipIf && cond) begin
            p_n = seqP + 14'h0001;
          end
          st_n = oai_pkg::ST_IDLE;
          if (exe.setRet) begin
            // RL2 store the pointer into bits 0-13 of the target
            sd_n = {10'h000, seqP};
            i_n.k = `OAI_K_IMM;
            p_n = iReg.y + 14'h0001;
            st_n = oai_pkg::ST_RMW;
          end else if (exe.store) begin
            sd_n = exe.data;
            st_n = (iReg.k == `OAI_K_FULL) ? oai_pkg::ST_WRITE : oai_pkg::ST_RMW;
          end
          halt_n = exe.halt | halt_n;
        end
      end
      oai_pkg::ST_RMW: begin
        if (!waitReg) begin
          go = 1'b1;
          goAddr = iReg.y;
        end else if (memDone) begin
          // RL11 RL12 RL13 merge keeps the untouched part of the word
          sd_n = storeWord;
          st_n = oai_pkg::ST_WRITE;
        end
      end
      oai_pkg::ST_WRITE: begin
        if (!waitReg) begin
          go = 1'b1;
          goWr = 1'b1;
          goAddr = iReg.y;
          goData = sdReg;
        end else if (memDone) begin
          st_n = oai_pkg::ST_IDLE;
        end
      end
      oai_pkg::ST_IO: begin
        if (!waitReg) begin
          go = 1'b1;
          goWr = ioWr;
          goAddr = ioAddr;
          goData = ioData;
        end else if (memDone) begin
          if (!ioWr && ioReg.wide) begin
            // RL7 low sector from Y, high sector from Y+1
            if (stepReg) begin
              x_n[29:15] = mReg[14:0];
            end else begin
              x_n[14:0] = mReg[14:0];
            end
          end else if (!ioWr) begin
            x_n = {6'h00, mReg[23:0]};
          end
          // RL8 counter-increment register forms the updated word
          z_n = mReg[23:0] + ioReg.data[23:0];
          step_n = ~last;
          if (last) begin
            rsp_n.ack = 1'b1;
            rsp_n.data = x_n;
            st_n = oai_pkg::ST_IDLE;
          end
        end
      end
      default: st_n = oai_pkg::ST_IDLE;
    endcase
    // parity during channel reads goes one way, program reads the other
    if (parBad && stReg == oai_pkg::ST_IO) begin
      rsp_n.parErr = 1'b1;
    end
    // RL21 each source only when its reaction setting asks for it
    if (parBad && stReg == oai_pkg::ST_IO && syncBReg[2]) begin
      pend_n[`OAI_INT_IOPAR] = 1'b1;
    end
    if (parBad && stReg != oai_pkg::ST_IO && syncBReg[3]) begin
      pend_n[`OAI_INT_PGPAR] = 1'b1;
    end
    // RL22 rising edge of the manual control while running
    if (syncBReg[4] && !manPrevReg && run) begin
      pend_n[`OAI_INT_MANUAL] = 1'b1;
    end
    // a source raised in the cycle it is granted stays pending
    pend_n = pend_n | (pendReg & ~take);
  end

  // memory access engine: S latched, M cleared or loaded at the start
  always_comb begin
    wait_n = waitReg;
    s_n = sReg;
    m_n = mReg;
    if (go) begin
      wait_n = 1'b1;
      // RL3 address latched as the access starts
      s_n = goAddr;
      // RL4 clear for a read; RL5 load with parity for a write
      m_n = goWr ? {~(^goData), goData} : `OAI_M_RST;
    end else if (waitReg && memSenseValid && !wrReg) begin
      // RL4 sensed word captured, then driven back as restore data
      m_n = memSense;
    end
    if (done) begin
      wait_n = 1'b0;
    end
  end

  // all state registers except the panel pin flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stReg <= oai_pkg::ST_IDLE; iReg <= '0; pReg <= `OAI_P_RST; faReg <= `OAI_P_RST;
      sReg <= 14'h0000; mReg <= `OAI_M_RST; sdReg <= 24'h000000; zReg <= 24'h000000;
      xReg <= 30'h00000000; ioReg <= '0; rspReg <= '0; opReg <= '0; pendReg <= 4'h0;
      intReg <= 1'b0; haltReg <= 1'b0; ovfReg <= 1'b0; waitReg <= 1'b0;
      stepReg <= 1'b0; startReg <= 1'b0; wrReg <= 1'b0;
    end else begin
      stReg <= st_n; iReg <= i_n; pReg <= p_n; faReg <= fa_n;
      sReg <= s_n; mReg <= m_n; sdReg <= sd_n; zReg <= z_n;
      xReg <= x_n; ioReg <= io_n; rspReg <= rsp_n; opReg <= op_n; pendReg <= pend_n;
      intReg <= int_n; haltReg <= halt_n; ovfReg <= ovf_n; waitReg <= wait_n;
      stepReg <= step_n; startReg <= go;
      wrReg <= go ? goWr : wrReg;
    end
  end

  // outputs straight from the registers
  assign memReq   = '{startReg, wrReg, sReg, mReg};
  assign opnd     = opReg;
  assign ioRsp    = rspReg;
  assign rangeOvf = ovfReg;
  assign nextPtr  = pReg;
  assign intMode  = intReg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic stEx, jmpAny;
  assign stEx   = (stReg == oai_pkg::ST_EXEC) && exe.done;
  assign jmpAny = exe.jump || (exe.jumpIf && cond) || exe.setRet;
  sequence sReadSense;
    waitReg && !wrReg && memSenseValid;
  endsequence
  sequence sFetchIssue;
    stReg == oai_pkg::ST_FETCH && !waitReg;
  endsequence
  a_seq_incr: assert property (stEx && !intReg && !jmpAny && !(exe.skipIf && cond) // RL1
    |=> pReg == $past(pReg) + 14'h0001) else $error("pointer did not step by one");
  a_skip_two: assert property (stEx && !intReg && !jmpAny && exe.skipIf && cond // RL1
    |=> pReg == $past(pReg) + 14'h0002) else $error("taken skip did not add two");
  a_jump_load: assert property (stEx && exe.jump && !exe.setRet && !(exe.skipIf && cond) // RL2
    |=> pReg == $past(iReg.y)) else $error("jump did not load pointer");
  a_addr_latch: assert property (sFetchIssue // RL3
    |=> startReg && sReg == $past(faReg)) else $error("fetch address not latched");
  a_buf_clear: assert property (startReg && !wrReg |-> mReg == `OAI_M_RST) // RL4
    else $error("buffer not cleared on read");
  a_sense_load: assert property (sReadSense |=> mReg == $past(memSense)) // RL4
    else $error("sensed word not captured");
  a_write_keep: assert property (waitReg && wrReg && memSenseValid |=> $stable(mReg)) // RL5
    else $error("write access captured sensed word");
  a_parity_gen: assert property (startReg && wrReg |-> ^mReg) // RL6
    else $error("write parity not odd");
  a_wide_pair: assert property (stReg == oai_pkg::ST_IO && !waitReg && stepReg && ioReg.wide // RL7
    |=> sReg == $past(ioReg.addr) + 14'h0001) else $error("high sector not at Y+1");
  a_index_ovf: assert property (stReg == oai_pkg::ST_INDEX && done && idxSum[14] // RL15
    |=> ovfReg) else $error("index carry missed");
  a_int_vector: assert property (stReg == oai_pkg::ST_IDLE && run && !ioReq.req && anyPend // RL18
    |=> intReg && faReg == $past(vecAddr) ##1 startReg && sReg == $past(faReg))
    else $error("interrupt fetch not from vector");
  a_int_noinc: assert property (stEx && intReg && !jmpAny && !exe.skipIf // RL18
    |=> $stable(pReg)) else $error("pointer moved after interrupt instruction");
  a_int_boundary: assert property (intReg && !$past(intReg) |-> $past(stReg) == oai_pkg::ST_IDLE) // RL19
    else $error("interrupt taken mid instruction");
endmodule // oai_unit
`default_nettype wire

// *** dv/oai_core_model.sv ***
// core memory model: sense then done per access, writes the buffer back at the end
`timescale 1ns/1ps
`default_nettype none
module oai_core_model (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // access request and pacing
  input  wire oai_pkg::oai_mem_req_t memReq,
  input  wire logic                  slow,
  // answer
  output logic                       memSenseValid,
  output logic [24:0]                memSense,
  output logic                       memDone
);
  logic [24:0] mem [16384];
  logic [13:0] adr;
  logic [2:0]  ph;
  // one access at a time; slow adds a cycle before the sense
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 3'h0;
      memSenseValid <= 1'b0;
      memDone <= 1'b0;
      memSense <= 25'h0AAAAAA;
    end else begin
      memSenseValid <= 1'b0;
      memDone <= 1'b0;
      memSense <= ~memSense; // never a stale word outside the sense cycle
      case (ph)
        3'h0: if (memReq.start) begin
          adr <= memReq.addr;
          ph <= slow ? 3'h1 : 3'h2;
        end
        3'h1: ph <= 3'h2;
        3'h2: begin
          memSenseValid <= 1'b1;
          memSense <= mem[adr];
          ph <= 3'h3;
        end
        3'h3: begin
          memDone <= 1'b1;
          ph <= 3'h4;
        end
        default: begin
          mem[adr] <= memReq.data;
          ph <= 3'h0;
        end
      endcase
    end
  end
endmodule // oai_core_model
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench: short program, manual vector, channel transfers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic runSw = 1'b0;
  logic manualIntSw = 1'b0;
  logic chanParResp = 1'b0;
  logic trapResp = 1'b0;
  logic progParResp = 1'b0;
  logic clrOvf = 1'b0;
  logic memSenseValid, memDone, rangeOvf, intMode;
  logic [24:0] memSense;
  logic [13:0] nextPtr;
  oai_pkg::oai_mem_req_t memReq;
  oai_pkg::oai_opnd_t opnd;
  oai_pkg::oai_io_rsp_t ioRsp;
  oai_pkg::oai_exec_t exe = '0;
  oai_pkg::oai_io_req_t ioReq = '0;
  int n_mismatch = 0;
  int checks_done = 0;
  // memory image: location in the top 14 bits, word below
  logic [37:0] img [10] = '{38'h0000070040, 38'h0001003F01, 38'h00400541FF, 38'h0041060100,
    38'h0042090100, 38'h01005A39FF, 38'h0013070077, 38'h0044040100, 38'h03007FFFFF, 38'h0010070000};
  always #20 clk_sys = ~clk_sys;
  // function 2 takes its option field as a skip code
  oai_unit #(.LCODE_FN(32'h00000004)) oai_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq),
    .memSenseValid(memSenseValid), .memSense(memSense), .memDone(memDone), .opnd(opnd), .exe(exe),
    .ioReq(ioReq), .ioRsp(ioRsp), .runSw(runSw), .trapResp(trapResp), .chanParResp(chanParResp),
    .progParResp(progParResp), .manualIntSw(manualIntSw), .clrOvf(clrOvf), .rangeOvf(rangeOvf),
    .nextPtr(nextPtr), .intMode(intMode));
  oai_core_model oai_core_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq), .slow(slow),
    .memSenseValid(memSenseValid), .memSense(memSense), .memDone(memDone));
  task automatic chk(input string nm, input logic [29:0] seen, input logic [29:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [24:0] pw(input logic [23:0] d);
    return {~^d, d}; // odd parity over all 25 bits
  endfunction
  // wait for an access start at a location, then look at the pointer
  task automatic fetch(input logic [13:0] a, input logic [13:0] p);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (memReq.start === 1'b1 && memReq.addr === a) break;
    end
    chk("fetch", 30'(i < 60), 30'h1);
    chk("nextPtr", 30'(nextPtr), 30'(p));
  endtask
  // operand handed over: compare it, then answer with one exec word
  task automatic step(input logic [13:0] ea, input logic [23:0] op, input logic im, input logic [30:0] ex);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (opnd.valid === 1'b1) break;
    end
    chk("ea", 30'(opnd.ea), 30'(ea));
    chk("opnd", 30'(opnd.opnd), 30'(op));
    chk("intMode", 30'(intMode), 30'(im));
    @(posedge clk_sys);
    exe <= ex;
    @(posedge clk_sys);
    exe <= '0;
  endtask
  // channel transfer; request held until the acknowledge cycle has passed
  task automatic io(input logic [2:0] f, input logic [13:0] a, input logic [29:0] d);
    int i;
    @(posedge clk_sys);
    ioReq <= {1'b1, f, a, d};
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (ioRsp.ack === 1'b1) break;
    end
    chk("ack", 30'(i < 60), 30'h1);
    @(posedge clk_sys);
    ioReq <= '0;
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog well beyond the whole sequence
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
  // main sequence
  initial begin
    foreach (img[j]) oai_core_model_i.mem[img[j][37:24]] = pw(img[j][23:0]);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("nextPtr", 30'(nextPtr), 30'h0); // cleared pointer
    runSw <= 1'b1;
    fetch(14'h0000, 14'h0000); // start location
    step(14'h0040, 24'h000040, 1'b0, 31'h48000000); // immediate then jump
    fetch(14'h0040, 14'h0040); // jump target
    step(14'h0100, 24'hFFF9FF, 1'b0, 31'h40000000); // indexed right half
    chk("rangeOvf", 30'(rangeOvf), 30'h1); // index carry
    fetch(14'h0041, 14'h0041); // step by one
    @(posedge clk_sys);
    clrOvf <= 1'b1;
    @(posedge clk_sys);
    clrOvf <= 1'b0;
    step(14'h0100, 24'h0005A3, 1'b0, 31'h42000ABC); // left half fetch
    fetch(14'h0042, 14'h0042); // step after store
    chk("merged", 30'(oai_core_model_i.mem[14'h0100]), 30'(pw(24'hABC9FF))); // store merge
    chk("rangeOvf", 30'(rangeOvf), 30'h0); // flag cleared
    @(posedge clk_sys);
    manualIntSw <= 1'b1;
    repeat (3) @(posedge clk_sys);
    manualIntSw <= 1'b0;
    step(14'h0100, 24'hABC9FF, 1'b0, 31'h60000000); // minus code on full word
    fetch(14'h0013, 14'h0044); // vector after completion
    step(14'h0077, 24'h000077, 1'b1, 31'h40000000); // vectored instruction
    fetch(14'h0044, 14'h0044); // pointer not stepped
    step(14'h0100, 24'hABC9FF, 1'b0, 31'h41000000); // full word then halt
    runSw <= 1'b0;
    slow <= 1'b1;
    io(3'h6, 14'h0200, 30'h091A5678); // wide write
    chk("lowSector", 30'(oai_core_model_i.mem[14'h0200]), 30'(pw(24'h005678))); // low half to Y
    chk("highSector", 30'(oai_core_model_i.mem[14'h0201]), 30'(pw(24'h001234))); // high half to Y+1
    io(3'h2, 14'h0200, 30'h0); // wide read
    chk("ioData", 30'(ioRsp.data), 30'h091A5678); // read back
    chk("restored", 30'(oai_core_model_i.mem[14'h0201]), 30'(pw(24'h001234))); // word restored
    io(3'h1, 14'h0300, 30'h1); // count increment
    chk("count", 30'(oai_core_model_i.mem[14'h0300]), 30'(pw(24'h800000))); // carry into sign
    chanParResp <= 1'b1;
    trapResp <= 1'b1;
    progParResp <= 1'b1;
    oai_core_model_i.mem[14'h0011] = 25'h0000000;
    oai_core_model_i.mem[14'h0201] = 25'h1001234;
    io(3'h2, 14'h0200, 30'h0); // bad parity on a channel read
    chk("parErr", 30'(ioRsp.parErr), 30'h1); // parity checked
    runSw <= 1'b1;
    fetch(14'h0011, 14'h0045); // channel parity vector
    fetch(14'h0010, 14'h0045); // fault first
    step(14'h0000, 24'h000000, 1'b1, 31'h40000000); // vectored immediate
    fetch(14'h0012, 14'h0045); // program parity
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
